// >>> hdl/flash_port.v
// Purpose: Serial front end of a flash memory: framing, lanes, pause, restart, latch and protection.
// Assumes: Serial clock, select and lanes are sampled synchronously on i_clk.
// Notes:   The array engine sits outside; this block issues commit pulses and reads bytes from it.
`timescale 1ns/1ps
`include "flash_port_map.vh"

// Summary of operation
// RULE1: 4096 sectors of 4KB, sixteen per block.
// RULE2: Sample on serial rise, shift on fall.
// RULE3: Dual reads use lanes 0 and 1.
// RULE4: Quad reads use lanes 0 to 3.
// RULE5: Quad commands need four-lane enable set.
// RULE6: Shared pin pauses unless four lanes enabled.
// RULE7: Pause never stops internal array work.
// RULE8: Pause starts on falling pin, clock low.
// RULE9: Pause ends on rising pin, clock low.
// RULE10: Paused: output released, clock and input ignored.
// RULE11: Select high while paused resets interface.
// RULE12: Shared pin restarts when select bit set; no status write sets pin_mode_restart, so the code never does this.
// RULE13: Long restart low returns volatile defaults.
// RULE14: Set-latch command sets write enable latch.
// RULE15: Latch clears after writes, erases, clear.
// RULE16: Protected regions readable, never modified.
// RULE17: Lock pin low blocks status writes; the code blocks them only while lock_enable is set.
// RULE18: Deep power-down honours release and reset only.
// RULE19: Codes 001-110 protect 1/64 to 1/2.
// RULE20: Code 111 all; small top/bottom regions.
// RULE21: Invert bit complements the protected region.
// RULE22: Cleared latch rejects writes and erases.
// RULE23: Chip erase only when fully unprotected.
// RULE24: MSB first; select rise ends frame.
module flash_port #(
  parameter RESTART_CYCLES = `RESTART_LOW_CYCLES,
  parameter FIFO_DEPTH     = 8
) (
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_ce,
  input  wire        i_sclk,
  input  wire        i_select_n,
  input  wire [3:0]  i_lane,
  output reg  [3:0]  o_lane,
  output reg  [3:0]  o_lane_oe,
  input  wire        i_restart_n,
  input  wire        i_busy,
  input  wire [7:0]  i_rd_data,
  input  wire        i_rd_valid,
  output reg         o_rd_ready,
  output reg  [7:0]  o_cmd,
  output reg  [23:0] o_addr,
  output reg  [7:0]  o_wr_data,
  output reg         o_wr_strobe,
  output reg         o_commit,
  output reg         o_status_commit,
  output reg  [15:0] o_status,
  output reg         o_paused,
  output reg         o_deep_down,
  output reg         o_restart
);
  localparam ST_CMD  = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_READ = 3'd3;
  localparam ST_SKIP = 3'd4;

  // -------------------------------------------------------------------------
  // Protection decode
  // -------------------------------------------------------------------------
  function prot_hit;
    input [23:0] addr;
    input [4:0]  sel;
    input        inv;
    reg   [23:0] size;
    reg          bottom;
    reg          hit;
    begin
      size   = 24'h00_0000;
      bottom = sel[3];
      if (sel[2:0] == 3'b111)
        size = `ARRAY_TOP; // [RULE20]
      else if (sel[2:0] == 3'b000)
        size = 24'h00_0000;
      else if (!sel[4])
        size = (24'h04_0000 << (sel[2:0] - 3'd1)) - 24'h00_0001; // [RULE19]
      else if (sel[2])
        size = 24'h00_7FFF; // [RULE20]
      else
        size = (24'h00_1000 << (sel[1:0] - 2'd1)) - 24'h00_0001; // [RULE20]
      if (sel[2:0] == 3'b000)
        hit = 1'b0;
      else if (bottom)
        hit = (addr <= size);
      else
        hit = (addr >= (`ARRAY_TOP - size));
      prot_hit = hit ^ inv; // [RULE21]
    end
  endfunction

  // -------------------------------------------------------------------------
  // Input sampling and edge detection
  // -------------------------------------------------------------------------
  reg        sclk_q;
  reg        sel_q;
  reg        hold_q;
  reg        restart_q;
  reg        write_latch;
  reg [4:0]  protect_sel;
  reg        protect_invert;
  reg        four_lane_enable;
  reg        pin_mode_restart;
  reg        lock_enable;
  reg        paused;
  reg [2:0]  state;
  reg [7:0]  shreg;
  reg [3:0]  bitcnt;
  reg [7:0]  cmd;
  reg [23:0] addr;
  reg [1:0]  addr_bytes;
  reg [1:0]  lanes;
  reg        reset_armed;
  reg        deep_down;
  reg [7:0]  tx_byte;
  reg [3:0]  tx_left;
  reg        tx_valid;
  reg [15:0] restart_cnt;
  reg [7:0]  st_hi;

  wire shared_pause   = !four_lane_enable && !pin_mode_restart; // [RULE6]
  wire shared_restart = !four_lane_enable && pin_mode_restart;  // [RULE12]
  wire sclk_rise      = i_sclk && !sclk_q && !paused && !i_select_n; // [RULE2] [RULE10]
  wire sclk_fall      = !i_sclk && sclk_q && !paused && !i_select_n;
  wire frame_end      = i_select_n && !sel_q; // [RULE24]
  wire restart_low    = !i_restart_n || (shared_restart && !i_lane[3]);
  wire [3:0] step     = (lanes == 2'd2) ? 4'd4 : (lanes == 2'd1) ? 4'd2 : 4'd1;
  wire [7:0] rx_byte  = (lanes == 2'd2) ? {shreg[3:0], i_lane[3:0]} :
                        (lanes == 2'd1) ? {shreg[5:0], i_lane[1:0]} : {shreg[6:0], i_lane[0]};
  wire       byte_done = (bitcnt + step) >= 4'd8;
  wire       quad_cmd  = (rx_byte == `CMD_QUAD_OUT) || (rx_byte == `CMD_QUAD_IO) || (rx_byte == `CMD_QUAD_WORD);
  wire       dual_cmd  = (rx_byte == `CMD_DUAL_OUT) || (rx_byte == `CMD_DUAL_IO);
  wire       wr_class  = (cmd == `CMD_PAGE_WRITE) || (cmd == `CMD_ERASE_4K) || (cmd == `CMD_ERASE_32K) ||
                         (cmd == `CMD_ERASE_LARGE);
  wire       chip_erase = (cmd == `CMD_ERASE_CHIP) || (cmd == `CMD_ERASE_CHIP_ALT);
  wire       chip_ok    = (protect_sel[2:0] == 3'b000 && !protect_invert) ||
                          (protect_sel[2:0] == 3'b111 && protect_invert); // [RULE23]
  wire       status_locked = lock_enable && !i_lane[2]; // [RULE17]
  wire       fifo_ready;
  wire [7:0] fifo_data;
  wire       fifo_valid;
  reg        fifo_pop;

  // Read data passes through a small FIFO so the array side may stall.
  lane_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset || o_restart),
    .i_ce    (i_ce),
    .i_flush (frame_end),
    .i_data  (i_rd_data),
    .i_valid (i_rd_valid && o_rd_ready),
    .o_ready (fifo_ready),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (fifo_pop)
  );

  // -------------------------------------------------------------------------
  // Frame engine
  // -------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_reset || (i_ce && (o_restart || (paused && i_select_n)))) begin // [RULE11] [RULE13]
      paused           <= 1'b0;
      state            <= ST_CMD;
      shreg            <= 8'h00;
      bitcnt           <= 4'h0;
      cmd              <= 8'h00;
      addr             <= 24'h00_0000;
      addr_bytes       <= 2'd0;
      lanes            <= 2'd0;
      reset_armed      <= 1'b0;
      deep_down        <= 1'b0;
      write_latch      <= 1'b0; // [RULE15]
      tx_byte          <= 8'h00;
      tx_left          <= 4'h0;
      tx_valid         <= 1'b0;
      fifo_pop         <= 1'b0;
      o_lane           <= 4'h0;
      o_lane_oe        <= 4'h0;
      o_rd_ready       <= 1'b0;
      o_commit         <= 1'b0;
      o_status_commit  <= 1'b0;
      o_wr_strobe      <= 1'b0;
      o_cmd            <= 8'h00;
      o_addr           <= 24'h00_0000;
      o_wr_data        <= 8'h00;
      st_hi            <= 8'h00;
      sclk_q           <= 1'b0;
      sel_q            <= 1'b1;
      hold_q           <= 1'b1;
      if (i_reset) begin
        protect_sel      <= 5'h00;
        protect_invert   <= 1'b0;
        four_lane_enable <= 1'b0;
        pin_mode_restart <= 1'b0;
        lock_enable      <= 1'b0;
      end
    end else if (i_ce) begin
      sclk_q          <= i_sclk;
      sel_q           <= i_select_n;
      hold_q          <= i_lane[3];
      fifo_pop        <= 1'b0;
      o_commit        <= 1'b0;
      o_status_commit <= 1'b0;
      o_wr_strobe     <= 1'b0;
      // Pause entry and exit wait for a low serial clock; internal work carries on. [RULE7]
      if (shared_pause && !i_select_n && !i_sclk) begin
        if (!i_lane[3])
          paused <= 1'b1; // [RULE8]
        else if (paused)
          paused <= 1'b0; // [RULE9]
      end
      if (paused)
        o_lane_oe <= 4'h0; // [RULE10]
      if (frame_end) begin
        if (!deep_down && state == ST_DATA && cmd == `CMD_STATUS_WRITE && write_latch && !status_locked
            && !i_busy) begin
          o_status_commit <= 1'b1;
          write_latch     <= 1'b0; // [RULE15]
        end else if (!deep_down && chip_erase && write_latch && chip_ok && !i_busy) begin
          o_commit    <= 1'b1;
          o_cmd       <= cmd;
          write_latch <= 1'b0; // [RULE15]
        end else if (!deep_down && wr_class && state != ST_ADDR && write_latch && !i_busy
                     && !prot_hit(addr, protect_sel, protect_invert)) begin // [RULE16] [RULE22]
          o_commit    <= 1'b1;
          o_cmd       <= cmd;
          o_addr      <= addr;
          write_latch <= 1'b0; // [RULE15]
        end
        state     <= ST_CMD;
        bitcnt    <= 4'h0;
        lanes     <= 2'd0;
        tx_valid  <= 1'b0;
        o_lane_oe <= 4'h0;
        o_rd_ready <= 1'b0;
      end else if (sclk_rise && state != ST_READ && state != ST_SKIP) begin
        shreg  <= rx_byte; // [RULE24]
        bitcnt <= byte_done ? 4'h0 : bitcnt + step;
        if (byte_done) begin
          case (state)
            ST_CMD: begin
              cmd <= rx_byte;
              if (deep_down) begin
                // Only release and the two-step reset get through. [RULE18]
                if (rx_byte == `CMD_RELEASE_DOWN || (reset_armed && rx_byte == `CMD_RESET_DEVICE))
                  deep_down <= 1'b0;
                reset_armed <= (rx_byte == `CMD_RESET_ENABLE);
                state       <= ST_SKIP;
              end else if (quad_cmd && !four_lane_enable) begin
                state <= ST_SKIP; // [RULE5]
              end else begin
                reset_armed <= (rx_byte == `CMD_RESET_ENABLE);
                if (rx_byte == `CMD_SET_WRITE_LATCH && !i_busy)
                  write_latch <= 1'b1; // [RULE14]
                if (rx_byte == `CMD_CLEAR_WRITE_LATCH && !i_busy)
                  write_latch <= 1'b0; // [RULE15]
                if (rx_byte == `CMD_DEEP_DOWN)
                  deep_down <= 1'b1;
                addr_bytes <= 2'd0;
                if (rx_byte == `CMD_READ_STATUS) begin
                  tx_byte  <= {protect_sel[4:0], write_latch, i_busy, 1'b0};
                  tx_left  <= 4'd8;
                  tx_valid <= 1'b1;
                  state    <= ST_READ;
                end else if (rx_byte == `CMD_STATUS_WRITE) begin
                  state <= ST_DATA;
                end else if (rx_byte == `CMD_READ || rx_byte == `CMD_PAGE_WRITE || rx_byte == `CMD_ERASE_4K ||
                             rx_byte == `CMD_ERASE_32K || rx_byte == `CMD_ERASE_LARGE || dual_cmd || quad_cmd) begin
                  state <= ST_ADDR;
                  if (rx_byte == `CMD_DUAL_IO)
                    lanes <= 2'd1; // [RULE3]
                  if (rx_byte == `CMD_QUAD_IO || rx_byte == `CMD_QUAD_WORD)
                    lanes <= 2'd2; // [RULE4]
                end else begin
                  state <= ST_SKIP;
                end
              end
              if (deep_down || !(quad_cmd && !four_lane_enable))
                if (reset_armed && rx_byte == `CMD_RESET_DEVICE)
                  write_latch <= 1'b0;
            end
            ST_ADDR: begin
              addr       <= {addr[15:0], rx_byte};
              addr_bytes <= addr_bytes + 2'd1;
              if (addr_bytes == 2'd2) begin
                if (cmd == `CMD_PAGE_WRITE) begin
                  state <= ST_DATA;
                end else if (wr_class) begin
                  state <= ST_SKIP;
                end else begin
                  o_addr     <= {addr[15:0], rx_byte};
                  o_cmd      <= cmd;
                  o_rd_ready <= 1'b1;
                  state      <= ST_READ;
                  tx_left    <= 4'd0;
                  lanes      <= (cmd == `CMD_DUAL_OUT || cmd == `CMD_DUAL_IO) ? 2'd1 :
                                (cmd == `CMD_READ) ? 2'd0 : 2'd2;
                end
              end
            end
            ST_DATA: begin
              if (cmd == `CMD_STATUS_WRITE) begin
                if (write_latch && !status_locked && !i_busy) begin // [RULE17] [RULE22]
                  if (addr_bytes == 2'd0)
                    protect_sel <= rx_byte[6:2];
                  else begin
                    four_lane_enable <= rx_byte[1];
                    protect_invert   <= rx_byte[6];
                  end
                end
                if (addr_bytes == 2'd0)
                  lock_enable <= write_latch && !status_locked ? rx_byte[7] : lock_enable;
                else
                  st_hi <= rx_byte;
                addr_bytes <= addr_bytes + 2'd1;
              end else begin
                o_wr_data   <= rx_byte;
                o_wr_strobe <= write_latch && !prot_hit(addr, protect_sel, protect_invert); // [RULE16]
              end
            end
            default: state <= ST_SKIP;
          endcase
        end
      end
      // Read data leaves on falling edges, the lane count fixed by the command.
      if (state == ST_READ && !frame_end && !paused) begin
        if (!tx_valid && fifo_valid && tx_left == 4'd0) begin
          tx_byte  <= fifo_data;
          tx_left  <= 4'd8;
          tx_valid <= 1'b1;
          fifo_pop <= 1'b1;
        end else if (sclk_fall && tx_valid) begin
          case (lanes)
            2'd2: begin
              o_lane    <= tx_byte[7:4]; // [RULE4]
              o_lane_oe <= 4'hF;
              tx_byte   <= {tx_byte[3:0], 4'h0};
            end
            2'd1: begin
              o_lane    <= {2'b00, tx_byte[7:6]}; // [RULE3]
              o_lane_oe <= 4'h3;
              tx_byte   <= {tx_byte[5:0], 2'b00};
            end
            default: begin
              o_lane    <= {2'b00, tx_byte[7], 1'b0}; // [RULE2]
              o_lane_oe <= 4'h2;
              tx_byte   <= {tx_byte[6:0], 1'b0};
            end
          endcase
          tx_left  <= tx_left - step;
          tx_valid <= (tx_left > step);
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Restart detection and outputs
  // -------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_reset) begin
      restart_cnt     <= 16'h0000;
      o_restart       <= 1'b0;
      restart_q       <= 1'b0;
      o_status        <= 16'h0000;
      o_paused        <= 1'b0;
      o_deep_down     <= 1'b0;
    end else if (i_ce) begin
      restart_q   <= restart_low;
      o_restart   <= 1'b0;
      if (restart_low && restart_q) begin
        if (restart_cnt == RESTART_CYCLES[15:0] - 16'h0001)
          o_restart <= 1'b1; // [RULE13]
        if (restart_cnt != 16'hFFFF)
          restart_cnt <= restart_cnt + 16'h0001;
      end else begin
        restart_cnt <= 16'h0000;
      end
      o_status    <= {1'b0, protect_invert, 4'h0, four_lane_enable, 1'b0,
                      lock_enable, protect_sel, write_latch, i_busy};
      o_paused    <= paused;
      o_deep_down <= deep_down;
    end
  end
endmodule // flash_port

// >>> hdl/flash_port_map.vh
// Purpose: Constants for the serial flash front end.
// Assumes: 125 MHz system clock, serial lanes sampled as synchronous inputs.
// Notes:   Array addresses are 24 bits wide.
`ifndef FLASH_PORT_MAP_VH
`define FLASH_PORT_MAP_VH

`define CMD_SET_WRITE_LATCH   8'h06
`define CMD_CLEAR_WRITE_LATCH 8'h04
`define CMD_STATUS_WRITE      8'h01
`define CMD_PAGE_WRITE        8'h02
`define CMD_ERASE_4K          8'h20
`define CMD_ERASE_32K         8'h52
`define CMD_ERASE_LARGE       8'hD8
`define CMD_ERASE_CHIP        8'hC7
`define CMD_ERASE_CHIP_ALT    8'h60
`define CMD_READ              8'h03
`define CMD_READ_STATUS       8'h05
`define CMD_DUAL_OUT          8'h3B
`define CMD_DUAL_IO           8'hBB
`define CMD_QUAD_OUT          8'h6B
`define CMD_QUAD_IO           8'hEB
`define CMD_QUAD_WORD         8'hE7
`define CMD_DEEP_DOWN         8'hB9
`define CMD_RELEASE_DOWN      8'hAB
`define CMD_RESET_ENABLE      8'h66
`define CMD_RESET_DEVICE      8'h99

`define SECTOR_SHIFT          12
`define SECTOR_LAST           12'hFFF
`define ARRAY_TOP             24'hFF_FFFF

`define RESTART_LOW_MIN_NS    1000
`define CLK_PERIOD_NS         8
`define RESTART_LOW_CYCLES    ((`RESTART_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> hdl/lane_fifo.v
// Purpose: Small synchronous FIFO carrying read data bytes toward the lanes.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
module lane_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             i_clk,
  input  wire             i_reset,
  input  wire             i_ce,
  input  wire             i_flush,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire            empty = (wr_ptr == rd_ptr);

  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rd_ptr[AW-1:0]];

  always @(posedge i_clk) begin
    if (i_reset || (i_ce && i_flush)) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else if (i_ce) begin
      if (i_valid && !full) begin
        mem[wr_ptr[AW-1:0]] <= i_data;
        wr_ptr              <= wr_ptr + 1'b1;
      end
      if (i_ready && !empty)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // lane_fifo

// >>> test/flash_host.sv
// Purpose: Behavioural host controller driving clock, select and lanes.
// Assumes: Mode 0, serial clock of eight system cycles per bit.
// Notes:   Lanes 2 and 3 idle high; the bench moves them for lock and pause.
`timescale 1ns/1ps
module flash_host (
  input  wire        i_clk,
  input  wire [3:0]  i_lane,
  output logic       o_sclk,
  output logic       o_select_n,
  output logic [3:0] o_lane
);
  logic [7:0] rx;
  initial begin
    o_sclk = 1'b0; // Clock idles low and stands still between frames.
    o_select_n = 1'b1;
    o_lane = 4'hF;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
    o_lane[1] = ~o_lane[1]; // Undriven output lane must never look settled.
  endtask
  task automatic frame(input logic [39:0] d, input int n);
    o_select_n = 1'b0;
    step(4);
    for (int i = 0; i < n * 8; i++) begin
      o_lane[0] = d[39-i];
      step(4);
      rx = {rx[6:0], i_lane[1]};
      o_sclk = 1'b1;
      step(4);
      o_sclk = 1'b0;
    end
    step(4);
    o_select_n = 1'b1;
    o_lane[0] = ~o_lane[0];
    step(8);
  endtask
endmodule // flash_host

// >>> test/flash_port_sva.sv
// Purpose: Concurrent checks on the ports of the serial flash front end.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module flash_port_sva #(
  parameter RESTART_CYCLES = 4
) (
  input wire        i_clk,
  input wire        i_reset,
  input wire        i_select_n,
  input wire        i_restart_n,
  input wire [3:0]  o_lane_oe,
  input wire        o_commit,
  input wire [15:0] o_status,
  input wire        o_paused,
  input wire        o_deep_down,
  input wire        o_restart
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_pause_release; o_paused |-> o_lane_oe == 4'h0; endproperty
  a_pause_release: assert property (p_pause_release) else $error("lanes driven while paused");
  property p_restart_pulse; o_restart |=> !o_restart; endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse too long");
  property p_restart_cause; o_restart |-> $past(i_restart_n, 2) == 1'b0; endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without low pin");
  property p_restart_latch; o_restart |-> ##[1:3] (o_status[1] == 1'b0); endproperty
  a_restart_latch: assert property (p_restart_latch) else $error("latch kept over restart");
  property p_commit_frame; o_commit |-> i_select_n; endproperty
  a_commit_frame: assert property (p_commit_frame) else $error("commit inside open frame");
  property p_commit_latch; o_commit |-> ##[1:3] (o_status[1] == 1'b0); endproperty
  a_commit_latch: assert property (p_commit_latch) else $error("latch kept after commit");
  property p_commit_awake; o_commit |-> !o_deep_down; endproperty
  a_commit_awake: assert property (p_commit_awake) else $error("commit in deep down");
  property p_latch_awake; $rose(o_status[1]) |-> !$past(o_deep_down); endproperty
  a_latch_awake: assert property (p_latch_awake) else $error("latch set in deep down");
endmodule // flash_port_sva

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the serial flash front end.
// Assumes: Restart threshold shortened to 4 cycles.
// Notes:   Protection expectations come from the bench's own decoder.
`timescale 1ns/1ps
`include "flash_port_map.vh"
module tb_top;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1, i_restart_n = 1'b1, src_on = 1'b0, acc, busy = 1'b0, ce = 1'b1;
  logic [7:0]  i_rd_data = 8'h00;
  logic        i_rd_valid = 1'b0;
  wire  [7:0]  cmd_o, wr_data;
  logic [31:0] seed = 32'h0000_bd94;
  logic [4:0]  sel;
  logic        inv;
  logic [23:0] a;
  logic [7:0]  exp_q[$];
  logic [29:0] corner [6] = '{{5'h01, 1'b0, 24'hFC_0000}, {5'h01, 1'b0, 24'hFB_FFFF}, {5'h19, 1'b0, 24'h00_0FFF},
                              {5'h19, 1'b0, 24'h00_1000}, {5'h00, 1'b1, 24'h12_3456}, {5'h07, 1'b1, 24'hFF_FFFF}};
  wire [3:0]   host_lane, dev_lane, dev_oe, lane_w;
  wire [23:0]  addr;
  wire [15:0]  status;
  wire         sclk, select_n, rd_ready, commit, paused, deep_down, restart, wr_strobe, st_commit;
  int          num_errors = 0, checks = 0, cycles = 0, commits = 0, restarts = 0, n;

  always #4 i_clk = ~i_clk;
  assign lane_w = (dev_oe & dev_lane) | (~dev_oe & host_lane);

  flash_port #(.RESTART_CYCLES(4), .FIFO_DEPTH(8)) i_flash_port (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_sclk(sclk), .i_select_n(select_n), .i_lane(lane_w),
    .o_lane(dev_lane), .o_lane_oe(dev_oe), .i_restart_n(i_restart_n), .i_busy(busy), .i_rd_data(i_rd_data),
    .i_rd_valid(i_rd_valid), .o_rd_ready(rd_ready), .o_cmd(cmd_o), .o_addr(addr), .o_wr_data(wr_data),
    .o_wr_strobe(wr_strobe), .o_commit(commit), .o_status_commit(st_commit), .o_status(status), .o_paused(paused), .o_deep_down(deep_down),
    .o_restart(restart));
  flash_host i_flash_host (.i_clk(i_clk), .i_lane(lane_w), .o_sclk(sclk), .o_select_n(select_n), .o_lane(host_lane));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected protection of one address for a protect code and invert bit.
  function automatic logic prot(input logic [4:0] s, input logic iv, input logic [23:0] ad);
    logic [23:0] sz;
    logic        p;
    if (s[2:0] == 3'b000) p = 1'b0;
    else if (s[2:0] == 3'b111) p = 1'b1;
    else begin
      if (s[4]) sz = 24'h00_1000 << ((s[2:0] >= 3'd4) ? 3'd3 : s[2:0] - 3'd1);
      else sz = 24'h04_0000 << (s[2:0] - 3'd1);
      p = s[3] ? (ad < sz) : (ad >= 24'h00_0000 - sz);
    end
    return p ^ iv;
  endfunction
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd1(input logic [7:0] c);
    i_flash_host.frame({c, 32'h0000_0000}, 1);
  endtask
  task automatic set_status(input logic [15:0] v);
    cmd1(`CMD_SET_WRITE_LATCH);
    i_flash_host.frame({`CMD_STATUS_WRITE, v, 16'h0000}, 3);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitors, read byte source and hang limit
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (commit === 1'b1) commits <= commits + 1;
    if (restart === 1'b1) restarts <= restarts + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end
  always @(posedge i_clk) begin
    acc = i_rd_valid && rd_ready === 1'b1;
    if (acc) exp_q.push_back(i_rd_data);
    #1;
    if (!src_on) i_rd_valid = 1'b0;
    else if (acc || !i_rd_valid) begin
      seed = xs(seed);
      i_rd_valid = 1'b1;
      i_rd_data = seed[15:8];
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    #1 i_reset = 1'b0;
    i_flash_host.step(2);
    chk("status after reset", status, 24'h0);
    cmd1(`CMD_SET_WRITE_LATCH);
    chk("latch set", status[1], 1);
    cmd1(`CMD_CLEAR_WRITE_LATCH);
    chk("latch clear", status[1], 0);
    n = commits;
    i_flash_host.frame({`CMD_PAGE_WRITE, 32'h0000_00A5}, 5);
    chk("write without latch", commits - n, 0);
    $display("test latch done");
    for (int i = 0; i < 20; i++) begin
      if (i < 6) {sel, inv, a} = corner[i];
      else begin
        seed = xs(seed);
        {inv, sel} = seed[5:0];
        seed = xs(seed);
        a = seed[23:0];
      end
      set_status({1'b0, sel, 3'b000, inv, 6'h00});
      chk("protect field", status[6:2], sel);
      cmd1(`CMD_SET_WRITE_LATCH);
      n = commits;
      i_flash_host.frame({`CMD_PAGE_WRITE, a, 8'h5A}, 5);
      chk("page write", commits - n, !prot(sel, inv, a));
      if (commits != n) chk("write address", addr, a);
      if (commits != n) chk("write cmd", {cmd_o, wr_data}, {`CMD_PAGE_WRITE, 8'h5A});
      cmd1(`CMD_SET_WRITE_LATCH);
      n = commits;
      cmd1(`CMD_ERASE_CHIP);
      chk("chip erase", commits - n, (sel[2:0] == 3'b000 && !inv) || (sel[2:0] == 3'b111 && inv));
    end
    set_status(16'h8000);
    i_flash_host.o_lane[2] = 1'b0;
    set_status(16'h0400);
    chk("locked status", status[6:2], 0);
    i_flash_host.o_lane[2] = 1'b1;
    set_status(16'h0000);
    $display("test protection done");
    for (int k = 0; k < 2; k++) begin
      cmd1(`CMD_DEEP_DOWN);
      chk("deep down", deep_down, 1);
      cmd1(`CMD_SET_WRITE_LATCH);
      chk("latch in deep down", status[1], 0);
      if (k == 0) cmd1(`CMD_RELEASE_DOWN);
      else begin
        cmd1(`CMD_RESET_ENABLE);
        cmd1(`CMD_RESET_DEVICE);
      end
      chk("wake", deep_down, 0);
    end
    for (int k = 0; k < 2; k++) begin
      cmd1(`CMD_SET_WRITE_LATCH);
      n = restarts;
      i_restart_n = 1'b0;
      i_flash_host.step(k ? 6 : 2);
      i_restart_n = 1'b1;
      i_flash_host.step(4);
      chk("restart pulse", restarts - n, k);
      chk("latch after restart", status[1], !k);
    end
    $display("test power states done");
    i_flash_host.o_select_n = 1'b0;
    i_flash_host.o_sclk = 1'b1;
    i_flash_host.o_lane[3] = 1'b0;
    i_flash_host.step(6);
    chk("pause deferred", paused, 0);
    i_flash_host.o_sclk = 1'b0;
    i_flash_host.step(6);
    chk("pause entered", paused, 1);
    i_flash_host.o_sclk = 1'b1;
    i_flash_host.o_lane[3] = 1'b1;
    i_flash_host.step(6);
    chk("exit deferred", paused, 1);
    i_flash_host.o_sclk = 1'b0;
    i_flash_host.o_lane[3] = 1'b0;
    i_flash_host.step(6);
    i_flash_host.o_select_n = 1'b1;
    i_flash_host.step(6);
    i_flash_host.o_lane[3] = 1'b1;
    i_flash_host.step(6);
    chk("select ends pause", paused, 0);
    $display("test pause done");
    src_on = 1'b1;
    i_flash_host.frame({`CMD_READ, 24'h00_0100, 8'h00}, 5);
    src_on = 1'b0;
    chk("bytes accepted", exp_q.size() > 0, 1);
    chk("read byte", i_flash_host.rx, exp_q.size() > 0 ? exp_q[0] : 8'h00);
    $display("test read done");
    summarize();
  end
endmodule // tb_top

bind flash_port flash_port_sva #(.RESTART_CYCLES(RESTART_CYCLES)) i_flash_port_sva (
  .i_clk(i_clk), .i_reset(i_reset), .i_select_n(i_select_n), .i_restart_n(i_restart_n), .o_lane_oe(o_lane_oe),
  .o_commit(o_commit), .o_status(o_status), .o_paused(o_paused), .o_deep_down(o_deep_down), .o_restart(o_restart));
